/* File: hdl/vmsvd_top.sv */
// Purpose: Voltage-ID mode selection and serial target decode for two planes
// Assumes: Pins are asynchronous to clk; serial clock is slow against clk
// Notes:   Off flags stop a plane
//
// The implementer's own choices: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module vmsvd_top
    import vmsvd_pkg::*;
#(
    parameter int IDLE_LIMIT = IDLE_CYCLES
) (
    input  wire logic        clk,
    input  wire logic        reset_n,
    // Pins
    input  wire logic        enablePin,
    input  wire logic        powerGoodIn,
    input  wire logic        serialVidClockPin,
    input  wire logic        serialVidDataPin,
    input  wire logic [5:0]  parallelCode,
    output var  logic        powerSaveOut,
    output var  logic [6:0]  coreDacTarget,
    output var  logic [6:0]  auxDacTarget,
    output var  logic        corePlaneOff,
    output var  logic        auxPlaneOff,
    // AXI4-Lite slave
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output var  logic        s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output var  logic        s_axi_wready,
    output var  logic [1:0]  s_axi_bresp,
    output var  logic        s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output var  logic        s_axi_arready,
    output var  logic [31:0] s_axi_rdata,
    output var  logic [1:0]  s_axi_rresp,
    output var  logic        s_axi_rvalid,
    input  wire logic        s_axi_rready
);
    localparam int PIN_COUNT = 10;

    // Synchronised pins
    logic [PIN_COUNT-1:0] pinLevel;
    wire                  enableLevel    = pinLevel[9];
    wire                  powerGoodLevel = pinLevel[8];
    wire                  svcLevel       = pinLevel[7];
    wire                  svdLevel       = pinLevel[6];
    wire  [5:0]           parallelLevel  = pinLevel[5:0];
    wire                  modeStrapBit   = parallelLevel[1];

    vmsvd_sync #(
        .WIDTH    (PIN_COUNT)
    ) pinSync (
        .clk      (clk),
        .reset_n  (reset_n),
        .pinIn    ({enablePin, powerGoodIn, serialVidClockPin, serialVidDataPin, parallelCode}),
        .levelOut (pinLevel)
    );

    // Mode state and latched two-bit code
    vmsvd_mode_e modeReg;
    vmsvd_mode_e modeNext;
    logic [1:0]  pinCodeReg;
    logic        svcPrevReg;

    always_comb begin
        modeNext = modeReg;
        unique case (modeReg)
            MODE_OFF: begin
                if (enableLevel) begin
                    if (modeStrapBit) begin
                        modeNext = MODE_PARALLEL;
                    end else if (powerGoodLevel) begin
                        modeNext = MODE_FIXED;
                    end else begin
                        modeNext = MODE_SERIAL_BOOT;
                    end
                end
            end
            MODE_SERIAL_BOOT: begin
                if (powerGoodLevel) begin
                    modeNext = MODE_SERIAL_RUN;
                end
            end
            MODE_SERIAL_RUN: begin
                if (!powerGoodLevel) begin
                    modeNext = MODE_SERIAL_BOOT;
                end
            end
            MODE_FIXED: begin
                modeNext = MODE_FIXED;
            end
            MODE_PARALLEL: begin
                modeNext = MODE_PARALLEL;
            end
            default: begin
                modeNext = MODE_OFF;
            end
        endcase
        if (!enableLevel) begin
            modeNext = MODE_OFF;
        end
    end

    wire enterMode = (modeReg == MODE_OFF) && enableLevel;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            modeReg    <= MODE_OFF;
            pinCodeReg <= 2'h0;
            svcPrevReg <= 1'b0;
        end else begin
            modeReg    <= modeNext;
            svcPrevReg <= svcLevel;
            if (enterMode) begin
                pinCodeReg <= {svcLevel, svdLevel};
            end
        end
    end

    // Serial receiver, live only after power-good
    wire          rxEnable  = modeReg == MODE_SERIAL_RUN;
    wire          svcRise   = svcLevel && !svcPrevReg;
    logic         frameValid;
    vmsvd_frame_s frame;

    vmsvd_rx #(
        .IDLE_LIMIT (IDLE_LIMIT)
    ) serialRx (
        .clk        (clk),
        .reset_n    (reset_n),
        .rxEnable   (rxEnable),
        .bitStrobe  (svcRise),
        .bitValue   (svdLevel),
        .frameValid (frameValid),
        .frame      (frame)
    );

    // Address configuration register
    logic [31:0] addrCfgReg;
    wire  [7:0]  coreAddr = addrCfgReg[CFG_CORE_LSB +: 8];
    wire  [7:0]  auxAddr  = addrCfgReg[CFG_AUX_LSB +: 8];
    wire  [7:0]  bothAddr = addrCfgReg[CFG_BOTH_LSB +: 8];

    // Command decode
    wire hitBoth = frameValid && rxEnable && (frame.address == bothAddr);
    wire hitCore = frameValid && rxEnable && (frame.address == coreAddr);
    wire hitAux  = frameValid && rxEnable && (frame.address == auxAddr);
    wire takeCore = hitCore || hitBoth;
    wire takeAux  = hitAux || hitBoth;
    wire takeAny  = takeCore || takeAux;

    // Serial code to steps; codes at the top turn the plane off
    wire [6:0] cmdCode  = frame.data.serialVoltageCode;
    wire       cmdOff   = cmdCode >= SERIAL_OFF_CODE;
    wire [6:0] cmdSteps = (cmdCode > SERIAL_FLOOR) ? SERIAL_FLOOR : cmdCode;

    wire [6:0] bootSteps     = BOOT_STEPS[pinCodeReg];
    wire [6:0] fixedSteps    = FIXED_STEPS[pinCodeReg];
    wire [6:0] parallelSteps = parallelLevel[5] ? 7'(parallelLevel) + PAR_UPPER_BASE :
        {parallelLevel, 1'b0};

    // Plane targets
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            coreDacTarget <= TARGET_RESET;
            auxDacTarget  <= TARGET_RESET;
            corePlaneOff  <= 1'b1;
            auxPlaneOff   <= 1'b1;
            powerSaveOut  <= 1'b1;
        end else begin
            unique case (modeReg)
                MODE_SERIAL_BOOT: begin
                    coreDacTarget <= bootSteps;
                    auxDacTarget  <= bootSteps;
                    corePlaneOff  <= 1'b0;
                    auxPlaneOff   <= 1'b0;
                    powerSaveOut  <= 1'b1;
                end
                MODE_SERIAL_RUN: begin
                    if (takeCore) begin
                        coreDacTarget <= cmdSteps;
                        corePlaneOff  <= cmdOff;
                    end
                    if (takeAux) begin
                        auxDacTarget <= cmdSteps;
                        auxPlaneOff  <= cmdOff;
                    end
                    if (takeAny) begin
                        powerSaveOut <= frame.data.powerSave;
                    end
                end
                MODE_FIXED: begin
                    coreDacTarget <= fixedSteps;
                    auxDacTarget  <= fixedSteps;
                    corePlaneOff  <= 1'b0;
                    auxPlaneOff   <= 1'b0;
                    powerSaveOut  <= 1'b1;
                end
                MODE_PARALLEL: begin
                    coreDacTarget <= parallelSteps;
                    auxDacTarget  <= AUX_PARK_STEPS;
                    corePlaneOff  <= 1'b0;
                    auxPlaneOff   <= 1'b1;
                    powerSaveOut  <= 1'b1;
                end
                default: begin
                    corePlaneOff <= 1'b1;
                    auxPlaneOff  <= 1'b1;
                    powerSaveOut <= 1'b1;
                end
            endcase
        end
    end

    // Register bus, write side; address and data may come in either order
    logic       awHaveReg;
    logic       wHaveReg;
    logic [7:0] awAddrReg;
    logic [31:0] wDataReg;
    logic [3:0] wStrbReg;

    wire awTaken  = s_axi_awvalid && s_axi_awready;
    wire wTaken   = s_axi_wvalid && s_axi_wready;
    wire doWrite  = awHaveReg && wHaveReg && !s_axi_bvalid;
    wire wrCfg    = awAddrReg == ADDR_CFG_OFFSET;
    wire [31:0] byteMask = {{8{wStrbReg[3]}}, {8{wStrbReg[2]}},
                            {8{wStrbReg[1]}}, {8{wStrbReg[0]}}};

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            awHaveReg     <= 1'b0;
            wHaveReg      <= 1'b0;
            awAddrReg     <= 8'h00;
            wDataReg      <= 32'h00000000;
            wStrbReg      <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
            addrCfgReg    <= {8'h00, BOTH_ADDR_RESET, AUX_ADDR_RESET, CORE_ADDR_RESET};
        end else begin
            s_axi_awready <= doWrite || (!awHaveReg && !awTaken);
            s_axi_wready  <= doWrite || (!wHaveReg && !wTaken);
            if (awTaken) begin
                awHaveReg <= 1'b1;
                awAddrReg <= s_axi_awaddr;
            end
            if (wTaken) begin
                wHaveReg <= 1'b1;
                wDataReg <= s_axi_wdata;
                wStrbReg <= s_axi_wstrb;
            end
            if (doWrite) begin
                awHaveReg    <= 1'b0;
                wHaveReg     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wrCfg ? RESP_OKAY : RESP_SLVERR;
                if (wrCfg) begin
                    addrCfgReg <= (addrCfgReg & ~byteMask) | (wDataReg & byteMask);
                end
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Register bus, read side
    wire arTaken = s_axi_arvalid && s_axi_arready;
    wire rDone   = s_axi_rvalid && s_axi_rready;

    wire [31:0] statusWord = (32'(modeReg) << ST_MODE_LSB)
                           | (32'(powerGoodLevel) << ST_PGOOD_BIT)
                           | (32'(powerSaveOut) << ST_PSAVE_BIT)
                           | (32'(pinCodeReg) << ST_CODE_LSB);
    wire [31:0] targetWord = (32'(coreDacTarget) << TG_CORE_LSB)
                           | (32'(auxDacTarget) << TG_AUX_LSB)
                           | (32'(corePlaneOff) << TG_CORE_OFF_BIT)
                           | (32'(auxPlaneOff) << TG_AUX_OFF_BIT);
    wire rdCfg    = s_axi_araddr == ADDR_CFG_OFFSET;
    wire rdStatus = s_axi_araddr == STATUS_OFFSET;
    wire rdTarget = s_axi_araddr == TARGETS_OFFSET;
    wire rdHit    = rdCfg || rdStatus || rdTarget;
    wire [31:0] readWord = rdCfg    ? addrCfgReg :
                           rdStatus ? statusWord :
                           rdTarget ? targetWord : 32'h00000000;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= RESP_OKAY;
        end else begin
            s_axi_arready <= rDone || (!s_axi_rvalid && !arTaken);
            if (arTaken) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= readWord;
                s_axi_rresp  <= rdHit ? RESP_OKAY : RESP_SLVERR;
            end else if (rDone) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

/* File: include/vmsvd_pkg.sv */
// Purpose: Constants and types of the voltage-ID block
// Assumes: Targets count 12.5 mV steps below 1.55 V
// Notes:   Offsets are byte addresses
package vmsvd_pkg;

    // Register map
    localparam logic [7:0] ADDR_CFG_OFFSET = 8'h00;
    localparam logic [7:0] STATUS_OFFSET   = 8'h04;
    localparam logic [7:0] TARGETS_OFFSET  = 8'h08;

    // Serial word addresses after reset
    localparam logic [7:0] CORE_ADDR_RESET = 8'h01;
    localparam logic [7:0] AUX_ADDR_RESET  = 8'h02;
    localparam logic [7:0] BOTH_ADDR_RESET = 8'h03;

    // Field positions
    localparam int CFG_CORE_LSB    = 0;
    localparam int CFG_AUX_LSB     = 8;
    localparam int CFG_BOTH_LSB    = 16;
    localparam int ST_MODE_LSB     = 0;
    localparam int ST_PGOOD_BIT    = 4;
    localparam int ST_PSAVE_BIT    = 5;
    localparam int ST_CODE_LSB     = 8;
    localparam int TG_CORE_LSB     = 0;
    localparam int TG_AUX_LSB      = 8;
    localparam int TG_CORE_OFF_BIT = 16;
    localparam int TG_AUX_OFF_BIT  = 17;

    // Serial word layout
    localparam int WORD_BITS = 8;

    // Target decoding
    localparam logic [6:0] SERIAL_OFF_CODE  = 7'h7C;
    localparam logic [6:0] SERIAL_FLOOR     = 7'h54;
    localparam logic [6:0] AUX_PARK_STEPS   = 7'h54;
    localparam logic [6:0] PAR_UPPER_BASE   = 7'h1F;
    localparam logic [6:0] TARGET_RESET     = 7'h00;
    // Boot codes 00..11: 1.1, 1.0, 0.9, 0.8 V
    localparam logic [3:0][6:0] BOOT_STEPS  = {7'h3C, 7'h34, 7'h2C, 7'h24};
    // Fixed codes 00..11: 1.4, 1.2, 1.0, 0.8 V
    localparam logic [3:0][6:0] FIXED_STEPS = {7'h3C, 7'h2C, 7'h1C, 7'h0C};

    // Framing is dropped when the serial clock idles this long
    localparam int IDLE_CYCLES     = 200;

    // Bus responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        MODE_OFF         = 3'b000,
        MODE_SERIAL_BOOT = 3'b001,
        MODE_SERIAL_RUN  = 3'b010,
        MODE_FIXED       = 3'b011,
        MODE_PARALLEL    = 3'b100
    } vmsvd_mode_e;

    typedef struct packed {
        logic       powerSave;
        logic [6:0] serialVoltageCode;
    } vmsvd_word_s;

    typedef struct packed {
        logic [7:0]  address;
        vmsvd_word_s data;
    } vmsvd_frame_s;

endpackage

/* File: hdl/vmsvd_sync.sv */
// Purpose: Three-stage pin synchroniser
// Assumes: Output moves only when stages two and three agree
// Notes:   First stage feeds the second stage only
`timescale 1ns/1ps
`default_nettype none
module vmsvd_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             reset_n,
    input  wire logic [WIDTH-1:0] pinIn,
    output var  logic [WIDTH-1:0] levelOut
);
    logic [WIDTH-1:0] stage1Reg;
    logic [WIDTH-1:0] stage2Reg;
    logic [WIDTH-1:0] stage3Reg;
    wire  [WIDTH-1:0] agree = ~(stage2Reg ^ stage3Reg);

    initial begin
        if (WIDTH < 1) $error("vmsvd_sync: WIDTH must be positive");
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            stage1Reg <= '0;
            stage2Reg <= '0;
            stage3Reg <= '0;
            levelOut  <= '0;
        end else begin
            stage1Reg <= pinIn;
            stage2Reg <= stage1Reg;
            stage3Reg <= stage2Reg;
            levelOut  <= (agree & stage3Reg) | (~agree & levelOut);
        end
    end
endmodule
`default_nettype wire

/* File: hdl/vmsvd_rx.sv */
// Purpose: Collects serial bits into an address word and a data word
// Assumes: Bits arrive most significant first, one per serial clock rise
// Notes:   Idle serial clock or disable drops a partial frame
`timescale 1ns/1ps
`default_nettype none
module vmsvd_rx
    import vmsvd_pkg::*;
#(
    parameter int IDLE_LIMIT = IDLE_CYCLES
) (
    input  wire logic                   clk,
    input  wire logic                   reset_n,
    input  wire logic                   rxEnable,
    input  wire logic                   bitStrobe,
    input  wire logic                   bitValue,
    output var  logic                   frameValid,
    output var  vmsvd_pkg::vmsvd_frame_s frame
);
    localparam int FRAME_BITS = 2 * WORD_BITS;

    logic [FRAME_BITS-1:0] shiftReg;
    logic [4:0]            countReg;
    logic [15:0]           idleReg;

    wire lastBit  = bitStrobe && (countReg == 5'(FRAME_BITS - 1));
    wire idleOver = idleReg == 16'(IDLE_LIMIT);

    initial begin
        if (IDLE_LIMIT < 1 || IDLE_LIMIT > 65535) $error("vmsvd_rx: bad IDLE_LIMIT");
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            shiftReg   <= '0;
            countReg   <= '0;
            idleReg    <= '0;
            frameValid <= 1'b0;
            frame      <= '0;
        end else begin
            frameValid <= 1'b0;
            if (!rxEnable || (idleOver && !bitStrobe)) begin
                countReg <= '0;
                idleReg  <= '0;
            end else if (bitStrobe) begin
                shiftReg <= {shiftReg[FRAME_BITS-2:0], bitValue};
                idleReg  <= '0;
                countReg <= lastBit ? 5'h00 : countReg + 5'h01;
                if (lastBit) begin
                    frameValid <= 1'b1;
                    frame      <= {shiftReg[FRAME_BITS-2:0], bitValue};
                end
            end else if (countReg != 5'h00) begin
                idleReg <= idleReg + 16'h0001;
            end
        end
    end
endmodule
`default_nettype wire

/* File: bench/vmsvd_props.sv */
// Purpose: Port properties of the voltage-ID block
// Assumes: Pins held steady for 12 cycles after an enable edge
// Notes:   Windows of 8 cycles cover the pin synchronisers
`timescale 1ns/1ps
`default_nettype none
module vmsvd_props
    import vmsvd_pkg::*;
#(
    parameter int IDLE_LIMIT = IDLE_CYCLES
) (
    input wire logic        clk,
    input wire logic        reset_n,
    input wire logic        enablePin,
    input wire logic        powerGoodIn,
    input wire logic        serialVidClockPin,
    input wire logic        serialVidDataPin,
    input wire logic [5:0]  parallelCode,
    input wire logic        powerSaveOut,
    input wire logic [6:0]  coreDacTarget,
    input wire logic [6:0]  auxDacTarget,
    input wire logic        corePlaneOff,
    input wire logic        auxPlaneOff,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    wire logic [1:0] pinCode = {serialVidClockPin, serialVidDataPin};
    property p_boot;
        logic [1:0] c;
        ($rose(enablePin) && !powerGoodIn && !parallelCode[1], c = pinCode) |-> ##8
            coreDacTarget == 7'h24 + {c, 3'h0} && auxDacTarget == coreDacTarget;
    endproperty
    property p_fixed;
        logic [1:0] c;
        ($rose(enablePin) && powerGoodIn && !parallelCode[1], c = pinCode) |-> ##8
            coreDacTarget == 7'h0C + {c, 4'h0} && auxDacTarget == coreDacTarget;
    endproperty
    // Upper half of the parallel table moves in single steps, lower half in double steps
    property p_par;
        logic [6:0] e;
        ($rose(enablePin) && parallelCode[1], e = parallelCode[5] ?
            7'(parallelCode) + 7'h1F : {parallelCode, 1'h0}) |-> ##8
            coreDacTarget == e && auxPlaneOff && auxDacTarget == 7'h54 && powerSaveOut;
    endproperty
    a_boot_target: assert property (p_boot)
        else $error("boot target wrong");
    a_fixed_target: assert property (p_fixed)
        else $error("fixed target wrong");
    a_parallel_target: assert property (p_par)
        else $error("parallel target wrong");
    a_pg_gate: assert property ((enablePin && !powerGoodIn)[*8] ##1
        (enablePin && !powerGoodIn) |-> $stable(coreDacTarget) && $stable(auxDacTarget))
        else $error("targets moved before power-good");
    a_off_on_disable: assert property ($fell(enablePin) |-> ##8 corePlaneOff && auxPlaneOff)
        else $error("planes not off after disable");
    a_aux_floor: assert property (!auxPlaneOff |-> auxDacTarget <= 7'h54)
        else $error("aux target below floor");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
    a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while busy");
    cover property ($rose(enablePin) && !powerGoodIn);
    cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
    cover property (!corePlaneOff && coreDacTarget == 7'h54);
endmodule
`default_nettype wire

/* File: bench/vmsvd_host.sv */
// Purpose: Host side of the serial voltage-ID link
// Assumes: Pins idle high through pull-ups
// Notes:   Link clock stands still between frames, 800 ns period
`timescale 1ns/1ps
`default_nettype none
module vmsvd_host (
    input  wire logic clk,
    output var  logic svcPin,
    output var  logic svdPin,
    output var  logic powerGood
);
    initial begin
        svcPin = 1'h1;
        svdPin = 1'h1;
        powerGood = 1'h0;
    end
    task automatic setPins(input logic [1:0] c);
        @(posedge clk);
        svcPin <= c[1];
        svdPin <= c[0];
    endtask
    task automatic setGood(input logic v);
        @(posedge clk);
        powerGood <= v;
    endtask
    // Data changes as the link clock falls; after the last bit it returns high with the clock high
    task automatic sendFrame(input logic [15:0] f);
        for (int i = 15; i >= 0; i--) begin
            @(posedge clk);
            svcPin <= 1'h0;
            svdPin <= f[i];
            repeat (4) @(posedge clk);
            svcPin <= 1'h1;
            repeat (3) @(posedge clk);
        end
        @(posedge clk);
        svdPin <= 1'h1;
    endtask
endmodule
`default_nettype wire

/* File: bench/vmsvd_top_test.sv */
// Purpose: Self-checking bench of the voltage-ID block
// Assumes: Host model drives the link
// Notes:   Short idle limit keeps the run brief
`timescale 1ns/1ps
`default_nettype none
module vmsvd_top_test;
    import vmsvd_pkg::*;
    logic        clk;
    logic        reset_n = 1'h0;
    logic        enablePin = 1'h0;
    logic [5:0]  parallelCode = 6'h00;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    wire  logic  serial_vid_clock_pin, serial_vid_data_pin, pg, powerSave, coreOff, auxOff, awready, wready, bvalid, arready, rvalid;
    wire  logic [6:0]  coreT, auxT;
    wire  logic [1:0]  bresp, rresp;
    wire  logic [31:0] rdata;
    int          fails = 0;
    int          comparisons = 0;
    vmsvd_top #(.IDLE_LIMIT(20)) dut_u (
        .clk(clk), .reset_n(reset_n), .enablePin(enablePin), .powerGoodIn(pg),
        .serialVidClockPin(serial_vid_clock_pin), .serialVidDataPin(serial_vid_data_pin), .parallelCode(parallelCode),
        .powerSaveOut(powerSave), .coreDacTarget(coreT), .auxDacTarget(auxT),
        .corePlaneOff(coreOff), .auxPlaneOff(auxOff), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready)
    );
    vmsvd_host host_u (.clk(clk), .svcPin(serial_vid_clock_pin), .svdPin(serial_vid_data_pin), .powerGood(pg));
    initial begin
        clk = 1'h0;
        forever #50 clk = ~clk;
    end
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic final_report();
        $display("Counts: %0d comparisons, %0d fails", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic axiWr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        do begin
            @(posedge clk);
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
            r = bresp;
        end while (!bvalid);
        bready <= 1'h0;
    endtask
    task automatic rdChk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do begin
            @(posedge clk);
            if (arready) arvalid <= 1'h0;
        end while (!rvalid);
        rready <= 1'h0;
        chk("rdata", rdata, e);
        chk("rresp", {30'h0, rresp}, {30'h0, er});
    endtask
    // Targets expected at 7C or above go unchecked
    task automatic tgChk(input logic [6:0] c, input logic [6:0] x, input logic ps,
                         input logic [1:0] off);
        chk("off", {30'h0, coreOff, auxOff}, {30'h0, off});
        if (c < 7'h7C) chk("core", {25'h0, coreT}, {25'h0, c});
        if (x < 7'h7C) chk("aux", {25'h0, auxT}, {25'h0, x});
        chk("psave", {31'h0, powerSave}, {31'h0, ps});
    endtask
    task automatic startMode(input logic [5:0] pc, input logic good, input logic [1:0] c);
        host_u.setPins(c);
        host_u.setGood(good);
        parallelCode <= pc;
        repeat (4) @(posedge clk);
        enablePin <= 1'h1;
        repeat (12) @(posedge clk);
    endtask
    task automatic stopMode();
        @(posedge clk);
        enablePin <= 1'h0;
        repeat (12) @(posedge clk);
    endtask
    task automatic cmd(input logic [7:0] a, input logic [7:0] d, input logic [6:0] c,
                       input logic [6:0] x, input logic ps, input logic [1:0] off);
        host_u.sendFrame({a, d});
        repeat (10) @(posedge clk);
        tgChk(c, x, ps, off);
    endtask
    task automatic testRegs();
        logic [1:0] r;
        rdChk(8'h00, 32'h00030201, 2'h0);
        rdChk(8'h08, 32'h00030000, 2'h0);
        rdChk(8'h0C, 32'h0, 2'h2);
        axiWr(8'h08, 32'hFFFFFFFF, r);
        chk("bresp ro", {30'h0, r}, 32'h2);
        axiWr(8'h00, 32'h00131211, r);
        chk("bresp cfg", {30'h0, r}, 32'h0);
        rdChk(8'h00, 32'h00131211, 2'h0);
        $display("registers done");
    endtask
    task automatic testBoot();
        for (int c = 0; c < 4; c++) begin
            startMode(6'h00, 1'h0, c[1:0]);
            tgChk(7'h24 + 7'(c * 8), 7'h24 + 7'(c * 8), 1'h1, 2'h0);
            if (c < 3) stopMode();
        end
        rdChk(8'h04, 32'h00000321, 2'h0);
        cmd(8'h13, 8'h05, 7'h3C, 7'h3C, 1'h1, 2'h0);
        $display("boot done");
    endtask
    task automatic testSerial();
        host_u.setGood(1'h1);
        repeat (12) @(posedge clk);
        tgChk(7'h3C, 7'h3C, 1'h1, 2'h0);
        cmd(8'h11, 8'h90, 7'h10, 7'h3C, 1'h1, 2'h0);
        cmd(8'h12, 8'h05, 7'h10, 7'h05, 1'h0, 2'h0);
        cmd(8'h44, 8'h20, 7'h10, 7'h05, 1'h0, 2'h0);
        host_u.sendFrame({8'h13, 8'hE0});
        while (coreT === 7'h10) @(posedge clk);
        tgChk(7'h54, 7'h54, 1'h1, 2'h0);
        cmd(8'h11, 8'h4F, 7'h4F, 7'h54, 1'h0, 2'h0);
        cmd(8'h13, 8'h7B, 7'h54, 7'h54, 1'h0, 2'h0);
        cmd(8'h13, 8'hFC, 7'h7F, 7'h7F, 1'h1, 2'h3);
        host_u.setGood(1'h0);
        repeat (12) @(posedge clk);
        tgChk(7'h3C, 7'h3C, 1'h1, 2'h0);
        stopMode();
        chk("off", {30'h0, coreOff, auxOff}, 32'h3);
        $display("serial done");
    endtask
    task automatic testFixedPar();
        for (int c = 0; c < 4; c++) begin
            startMode(6'h00, 1'h1, c[1:0]);
            tgChk(7'h0C + 7'(c * 16), 7'h0C + 7'(c * 16), 1'h1, 2'h0);
            stopMode();
        end
        startMode(6'h3F, 1'h0, 2'h3);
        tgChk(7'h5E, 7'h54, 1'h1, 2'h1);
        host_u.setGood(1'h1);
        cmd(8'h13, 8'h05, 7'h5E, 7'h54, 1'h1, 2'h1);
        stopMode();
        startMode(6'h1E, 1'h1, 2'h3);
        tgChk(7'h3C, 7'h54, 1'h1, 2'h1);
        stopMode();
        $display("fixed and parallel done");
    endtask
    initial begin
        repeat (12) @(posedge clk);
        reset_n <= 1'h1;
        repeat (2) @(posedge clk);
        testRegs();
        testBoot();
        testSerial();
        testFixedPar();
        final_report();
    end
    // Whole run needs about 1600 cycles
    initial begin
        repeat (30000) @(posedge clk);
        fails++;
        final_report();
    end
endmodule
bind vmsvd_top vmsvd_props #(.IDLE_LIMIT(IDLE_LIMIT)) props_u (
    .clk, .reset_n, .enablePin, .powerGoodIn, .serialVidClockPin, .serialVidDataPin,
    .parallelCode, .powerSaveOut, .coreDacTarget, .auxDacTarget, .corePlaneOff,
    .auxPlaneOff, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arready,
    .s_axi_rdata, .s_axi_rvalid, .s_axi_rready
);
`default_nettype wire
